// File: hdl/dsos_pkg.sv
// Package for the drive status-output selector.
// Assumes one 50 MHz clock; no register bus, all settings are plain ports.
package dsos_pkg;

   // ****************************************************************
   // Selection codes
   // ****************************************************************
   localparam logic [5:0] SEL_NONE      = 6'h00;
   localparam logic [5:0] SEL_RUN       = 6'h01;
   localparam logic [5:0] SEL_SPD_ATT   = 6'h02;
   localparam logic [5:0] SEL_DES1      = 6'h03;
   localparam logic [5:0] SEL_DES2      = 6'h04;
   localparam logic [5:0] SEL_ZCMD      = 6'h05;
   localparam logic [5:0] SEL_ZCMD_STOP = 6'h06;
   localparam logic [5:0] SEL_OVTQ1     = 6'h07;
   localparam logic [5:0] SEL_OVTQ2     = 6'h08;
   localparam logic [5:0] SEL_READY     = 6'h09;
   localparam logic [5:0] SEL_LOWV      = 6'h0A;
   localparam logic [5:0] SEL_FAULT     = 6'h0B;
   localparam logic [5:0] SEL_BRAKE     = 6'h0C;
   localparam logic [5:0] SEL_HEAT      = 6'h0D;
   localparam logic [5:0] SEL_CHOP      = 6'h0E;
   localparam logic [5:0] SEL_CONTACTOR = 6'h0F;
   localparam logic [5:0] SEL_SLIP      = 6'h10;
   localparam logic [5:0] SEL_FAULT_DLY = 6'h11;
   localparam logic [5:0] SEL_CHOP_ERR  = 6'h13;
   localparam logic [5:0] SEL_WARN      = 6'h14;
   localparam logic [5:0] SEL_OVV_WARN  = 6'h15;
   localparam logic [5:0] SEL_OC_STALL  = 6'h16;
   localparam logic [5:0] SEL_OV_STALL  = 6'h17;
   localparam logic [5:0] SEL_EXT_CMD   = 6'h18;
   localparam logic [5:0] SEL_FWD       = 6'h19;
   localparam logic [5:0] SEL_REV       = 6'h1A;
   localparam logic [5:0] SEL_CUR_GE    = 6'h1B;
   localparam logic [5:0] SEL_CUR_LT    = 6'h1C;
   localparam logic [5:0] SEL_FRQ_GE    = 6'h1D;
   localparam logic [5:0] SEL_FRQ_LT    = 6'h1E;
   localparam logic [5:0] SEL_ZACT      = 6'h21;
   localparam logic [5:0] SEL_ZACT_STOP = 6'h22;
   localparam logic [5:0] SEL_FOPT1     = 6'h23;
   localparam logic [5:0] SEL_FOPT4     = 6'h26;
   localparam logic [5:0] SEL_SPD_ATT0  = 6'h28;

   // ****************************************************************
   // Control modes
   // ****************************************************************
   localparam logic [2:0] MODE_OPEN_VF  = 3'h0;
   localparam logic [2:0] MODE_ENC_VF   = 3'h1;
   localparam logic [2:0] MODE_SENSLESS = 3'h2;
   localparam logic [2:0] MODE_ENC_FOC  = 3'h3;
   localparam logic [2:0] MODE_ENC_TQ   = 3'h4;
   localparam logic [2:0] MODE_PM_FOC   = 3'h5;

   // ****************************************************************
   // Timing and reset values
   // ****************************************************************
   localparam int CLK_HZ          = 50_000_000;
   localparam int FAULT_DLY_US    = 10_000;
   localparam int FAULT_DLY_CYC   = CLK_HZ / 1_000_000 * FAULT_DLY_US;
   localparam int DELAY_TICK_US   = 1_000;
   localparam int TICK_CYC        = CLK_HZ / 1_000_000 * DELAY_TICK_US;
   localparam logic [15:0] DELAY_RST = 16'h0000;

   // ****************************************************************
   // Drive status carrier
   // ****************************************************************
   typedef struct packed {
      logic running;
      logic runCmd;
      logic speedAttained;
      logic desFreq1Hit;
      logic desFreq2Hit;
      logic freqCmdZero;
      logic outFreqZero;
      logic overTorque1;
      logic overTorque2;
      logic powerOk;
      logic abnormal;
      logic lowVoltageFlag;
      logic fault;
      logic lowVoltageStop;
      logic overheatWarn;
      logic chopperActive;
      logic contactorReq;
      logic slipErrorFlag;
      logic chopperError;
      logic warning;
      logic overVoltWarn;
      logic ocStall;
      logic ovStall;
      logic dirForward;
      logic dirReverse;
   } dsos_status_s;

endpackage

// File: hdl/dsos_selector.sv
// Status-output selector: maps per-terminal selection codes to levels.
// Assumes status inputs and settings are synchronous to refClk.
`timescale 1ns/1ns

module dsos_selector #(
   parameter int NUM_OUT = 12,
   parameter int FW      = 16,
   parameter int FAULT_DLY = dsos_pkg::FAULT_DLY_CYC
) (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // Drive status
   input  wire dsos_pkg::dsos_status_s status,
   input  wire logic [2:0]            controlMode,
   input  wire logic [FW-1:0]         outCurrent,
   input  wire logic [FW-1:0]         outFreq,
   // Settings
   input  wire logic [NUM_OUT*6-1:0]  selectCode,
   input  wire logic [NUM_OUT-1:0]    invertMask,
   input  wire logic [FW-1:0]         currentThreshold,
   input  wire logic [FW-1:0]         frequencyThreshold,
   input  wire logic [15:0]           brakeReleaseDelay,
   input  wire logic [15:0]           brakeEngageDelay,
   input  wire logic [7:0]            commandSourceSelect,
   input  wire logic [3:0]            faultOptionMask,
   // Terminals
   output logic      [NUM_OUT-1:0]    terminalOut
);

   // ****************************************************************
   // Brake state machine
   // ****************************************************************
   typedef enum logic [3:0] {
      BRK_ENGAGED   = 4'b0001,
      BRK_RELEASING = 4'b0010,
      BRK_RELEASED  = 4'b0100,
      BRK_ENGAGING  = 4'b1000
   } dsos_brake_e;

   dsos_brake_e brk_q;
   dsos_brake_e brk_d;
   logic [15:0] tickCnt_q;
   logic [15:0] msCnt_q;
   logic [31:0] faultCnt_q;
   logic        faultDly_q;
   logic        tick;
   logic        brakeOn;
   logic        timerDone;
   logic        msClear;
   logic        faultAny;
   logic        torqueMode;
   logic        ocStallOk;
   logic        curGe;
   logic        frqGe;
   logic [NUM_OUT-1:0] termLevel;

   assign tick      = tickCnt_q == 16'(dsos_pkg::TICK_CYC - 1);
   assign faultAny  = status.fault & ~status.lowVoltageStop;
   assign torqueMode = controlMode == dsos_pkg::MODE_ENC_TQ;
   assign ocStallOk = controlMode == dsos_pkg::MODE_OPEN_VF
                    | controlMode == dsos_pkg::MODE_ENC_VF
                    | controlMode == dsos_pkg::MODE_SENSLESS;
   assign curGe     = outCurrent >= currentThreshold;
   assign frqGe     = outFreq >= frequencyThreshold;
   assign brakeOn   = brk_q == BRK_RELEASED || brk_q == BRK_ENGAGING;
   assign timerDone = brk_q == BRK_RELEASING
                    ? msCnt_q >= brakeReleaseDelay
                    : msCnt_q >= brakeEngageDelay;
   assign msClear   = brk_q != brk_d;

   always_comb begin
      brk_d = brk_q;
      unique case (brk_q)
         BRK_ENGAGED: begin
            if (status.running) brk_d = BRK_RELEASING;
         end
         BRK_RELEASING: begin
            if (!status.running) brk_d = BRK_ENGAGED;
            else if (timerDone) brk_d = BRK_RELEASED;
         end
         BRK_RELEASED: begin
            if (!status.running) brk_d = BRK_ENGAGING;
         end
         BRK_ENGAGING: begin
            if (status.running) brk_d = BRK_RELEASED;
            else if (timerDone) brk_d = BRK_ENGAGED;
         end
         default: brk_d = BRK_ENGAGED;
      endcase
   end

   // Delay timers count whole milliseconds; settings are in ms units.
   // The tick restarts on every brake state change, so a delay is never cut
   // short by a partly elapsed millisecond.
   always_ff @(posedge ref_clk) begin
      if (rst || tick || msClear) tickCnt_q <= 16'h0000;
      else tickCnt_q <= tickCnt_q + 16'h0001;
   end

   always_ff @(posedge ref_clk) begin
      if (rst || msClear) msCnt_q <= dsos_pkg::DELAY_RST;
      else if (tick && msCnt_q != 16'hFFFF) msCnt_q <= msCnt_q + 16'h0001;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) brk_q <= BRK_ENGAGED;
      else brk_q <= brk_d;
   end

   // ****************************************************************
   // Delayed fault indication
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst || !faultAny) faultCnt_q <= 32'h0000_0000;
      else if (!faultDly_q) faultCnt_q <= faultCnt_q + 32'h0000_0001;
   end

   always_ff @(posedge ref_clk) begin
      if (rst || !faultAny) faultDly_q <= 1'b0;
      else if (faultCnt_q >= 32'(FAULT_DLY - 1)) faultDly_q <= 1'b1;
   end

   // ****************************************************************
   // Per-terminal selection
   // ****************************************************************
   function automatic logic selectLevel(input logic [5:0] code);
      logic lvl;
      lvl = 1'b0;
      unique case (code)
         dsos_pkg::SEL_RUN:       lvl = status.running | status.runCmd;
         dsos_pkg::SEL_SPD_ATT:   lvl = status.speedAttained;
         dsos_pkg::SEL_DES1:      lvl = status.desFreq1Hit & ~torqueMode;
         dsos_pkg::SEL_DES2:      lvl = status.desFreq2Hit & ~torqueMode;
         dsos_pkg::SEL_ZCMD:      lvl = status.freqCmdZero & status.running
                                      & ~torqueMode;
         dsos_pkg::SEL_ZCMD_STOP: lvl = (status.freqCmdZero | ~status.running)
                                      & ~torqueMode;
         dsos_pkg::SEL_OVTQ1:     lvl = status.overTorque1;
         dsos_pkg::SEL_OVTQ2:     lvl = status.overTorque2;
         dsos_pkg::SEL_READY:     lvl = status.powerOk & ~status.abnormal;
         dsos_pkg::SEL_LOWV:      lvl = status.lowVoltageFlag;
         dsos_pkg::SEL_FAULT:     lvl = faultAny;
         dsos_pkg::SEL_BRAKE:     lvl = brakeOn;
         dsos_pkg::SEL_HEAT:      lvl = status.overheatWarn;
         dsos_pkg::SEL_CHOP:      lvl = status.chopperActive;
         dsos_pkg::SEL_CONTACTOR: lvl = status.contactorReq;
         dsos_pkg::SEL_SLIP:      lvl = status.slipErrorFlag & ~torqueMode;
         dsos_pkg::SEL_FAULT_DLY: lvl = faultDly_q;
         dsos_pkg::SEL_CHOP_ERR:  lvl = status.chopperError;
         dsos_pkg::SEL_WARN:      lvl = status.warning;
         dsos_pkg::SEL_OVV_WARN:  lvl = status.overVoltWarn;
         dsos_pkg::SEL_OC_STALL:  lvl = status.ocStall & ocStallOk;
         dsos_pkg::SEL_OV_STALL:  lvl = status.ovStall;
         dsos_pkg::SEL_EXT_CMD:   lvl = commandSourceSelect != 8'h00;
         dsos_pkg::SEL_FWD:       lvl = status.dirForward;
         dsos_pkg::SEL_REV:       lvl = status.dirReverse;
         dsos_pkg::SEL_CUR_GE:    lvl = curGe;
         dsos_pkg::SEL_CUR_LT:    lvl = ~curGe;
         dsos_pkg::SEL_FRQ_GE:    lvl = frqGe;
         dsos_pkg::SEL_FRQ_LT:    lvl = ~frqGe;
         dsos_pkg::SEL_ZACT:      lvl = status.outFreqZero & ~torqueMode;
         dsos_pkg::SEL_ZACT_STOP: lvl = (status.outFreqZero | ~status.running)
                                      & ~torqueMode;
         dsos_pkg::SEL_SPD_ATT0:  lvl = status.speedAttained & ~torqueMode;
         default: begin
            if (code >= dsos_pkg::SEL_FOPT1 && code <= dsos_pkg::SEL_FOPT4)
               lvl = faultOptionMask[2'(code - dsos_pkg::SEL_FOPT1)];
            else
               lvl = 1'b0;
         end
      endcase
      return lvl;
   endfunction

   // Each terminal decodes its own code slice independently.
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         termLevel[i] = selectLevel(selectCode[i*6 +: 6])
                      ^ invertMask[i];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) terminalOut <= '0;
      else terminalOut <= termLevel;
   end

endmodule

// File: verification/dsos_relay_model.sv
// Relay bank model: each contact follows its terminal one clock late.
// Assumes terminal levels are synchronous to refClk.
`timescale 1ns/1ns
module dsos_relay_model #(
   parameter int NUM_OUT = 12
) (
   // Clock
   input  wire logic               ref_clk,
   // Terminals and contacts
   input  wire logic [NUM_OUT-1:0] terminalOut,
   output logic      [NUM_OUT-1:0] relayContact
);
   always_ff @(posedge ref_clk) begin
      relayContact <= terminalOut;
   end
endmodule

// File: verification/dsos_selector_sva.sv
// Checker for the status-output selector, watching terminal 0.
// Assumes the top module's ports and one clock domain.
`timescale 1ns/1ns
module dsos_selector_sva #(
   parameter int NUM_OUT   = 12,
   parameter int FW        = 16,
   parameter int FAULT_DLY = 20
) (
   // Clock and reset
   input wire logic                  ref_clk,
   input wire logic                  rst,
   // Watched signals
   input wire dsos_pkg::dsos_status_s status,
   input wire logic [2:0]            controlMode,
   input wire logic [FW-1:0]         outCurrent,
   input wire logic [FW-1:0]         outFreq,
   input wire logic [NUM_OUT*6-1:0]  selectCode,
   input wire logic [NUM_OUT-1:0]    invertMask,
   input wire logic [FW-1:0]         currentThreshold,
   input wire logic [FW-1:0]         frequencyThreshold,
   input wire logic [7:0]            commandSourceSelect,
   input wire logic [3:0]            faultOptionMask,
   input wire logic [NUM_OUT-1:0]    terminalOut
);
   wire [5:0] sel = selectCode[5:0];
   wire       on  = !invertMask[0];
   wire       flt = status.fault && !status.lowVoltageStop;
   int        cnt_q;
   always_ff @(posedge ref_clk) begin
      cnt_q <= (rst || !flt) ? 0 : cnt_q + 1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_clear;
      (sel == 6'h11 && on && !status.fault) [*4];
   endsequence
   property p_run;
      sel == 6'h01 && on && (status.running || status.runCmd)
      |=> terminalOut[0];
   endproperty
   a_run: assert property (p_run) else $error("run level wrong");
   property p_ready;
      sel == 6'h09 && on && status.powerOk && !status.abnormal
      |=> terminalOut[0];
   endproperty
   a_ready: assert property (p_ready) else $error("ready wrong");
   property p_fault;
      sel == 6'h0B && on && flt |=> terminalOut[0];
   endproperty
   a_fault: assert property (p_fault) else $error("fault wrong");
   property p_hold;
      sel == 6'h11 && on && flt && cnt_q < FAULT_DLY |=> !terminalOut[0];
   endproperty
   a_hold: assert property (p_hold) else $error("fault early");
   property p_late;
      sel == 6'h11 && on && flt && cnt_q >= FAULT_DLY |=> terminalOut[0];
   endproperty
   a_late: assert property (p_late) else $error("fault late");
   property p_drop;
      s_clear |-> !terminalOut[0];
   endproperty
   a_drop: assert property (p_drop) else $error("fault stuck");
   property p_torque;
      controlMode == 3'h4 && on
      && sel inside {6'h03, 6'h04, 6'h05, 6'h06, 6'h10, 6'h21, 6'h22, 6'h28}
      |=> !terminalOut[0];
   endproperty
   a_torque: assert property (p_torque) else $error("torque gate");
   property p_stall;
      sel == 6'h16 && on && controlMode > 3'h2 |=> !terminalOut[0];
   endproperty
   a_stall: assert property (p_stall) else $error("stall gate");
   property p_ext;
      sel == 6'h18 && on |=> terminalOut[0] == $past(|commandSourceSelect);
   endproperty
   a_ext: assert property (p_ext) else $error("source wrong");
   property p_cur;
      sel == 6'h1B && on
      |=> terminalOut[0] == $past(outCurrent >= currentThreshold);
   endproperty
   a_cur: assert property (p_cur) else $error("current cmp");
   property p_frq;
      sel == 6'h1E && on
      |=> terminalOut[0] == $past(outFreq < frequencyThreshold);
   endproperty
   a_frq: assert property (p_frq) else $error("freq cmp");
   property p_mask;
      sel == 6'h23 && on |=> terminalOut[0] == $past(faultOptionMask[0]);
   endproperty
   a_mask: assert property (p_mask) else $error("mask wrong");
   property p_res;
      !on && sel inside {6'h00, 6'h12, 6'h1F, 6'h20, 6'h27, 6'h29}
      |=> terminalOut[0];
   endproperty
   a_res: assert property (p_res) else $error("reserved");
endmodule

bind dsos_selector dsos_selector_sva #(
   .NUM_OUT(NUM_OUT), .FW(FW), .FAULT_DLY(FAULT_DLY)
) u_dsos_selector_sva (
   .ref_clk(ref_clk), .rst(rst), .status(status),
   .controlMode(controlMode), .outCurrent(outCurrent), .outFreq(outFreq),
   .selectCode(selectCode), .invertMask(invertMask),
   .currentThreshold(currentThreshold),
   .frequencyThreshold(frequencyThreshold),
   .commandSourceSelect(commandSourceSelect),
   .faultOptionMask(faultOptionMask), .terminalOut(terminalOut)
);

// File: verification/drive_status_output_selector_bench.sv
// Self-checking bench for the status-output selector.
// Assumes the design package and a relay model beside the design.
`timescale 1ns/1ns
module drive_status_output_selector_bench;
   localparam int N  = 12;
   localparam int FD = 20;
   logic                   ref_clk, rst;
   dsos_pkg::dsos_status_s status;
   logic [2:0]             controlMode;
   logic [15:0]            outCurrent, outFreq, curThr, frqThr, relD, engD;
   logic [N*6-1:0]         selectCode;
   logic [N-1:0]           invMask, terminalOut, relayContact, ex, last;
   logic [7:0]             cmdSrc;
   logic [3:0]             fMask;
   logic [5:0]             c;
   int                     n_errors, checked, seed, it, j;
   dsos_selector #(.NUM_OUT(N), .FW(16), .FAULT_DLY(FD)) u_dsos_selector (
      .ref_clk(ref_clk), .rst(rst), .status(status),
      .controlMode(controlMode), .outCurrent(outCurrent), .outFreq(outFreq),
      .selectCode(selectCode), .invertMask(invMask),
      .currentThreshold(curThr), .frequencyThreshold(frqThr),
      .brakeReleaseDelay(relD), .brakeEngageDelay(engD),
      .commandSourceSelect(cmdSrc), .faultOptionMask(fMask),
      .terminalOut(terminalOut));
   dsos_relay_model #(.NUM_OUT(N)) u_dsos_relay_model (
      .ref_clk(ref_clk), .terminalOut(terminalOut),
      .relayContact(relayContact));
   function automatic logic lvl(input logic [5:0] k);
      logic tq;
      dsos_pkg::dsos_status_s s;
      tq = controlMode == dsos_pkg::MODE_ENC_TQ;
      s = status;
      case (k)
         6'h01: lvl = s.running | s.runCmd;
         6'h02: lvl = s.speedAttained;
         6'h03: lvl = s.desFreq1Hit & !tq;
         6'h04: lvl = s.desFreq2Hit & !tq;
         6'h05: lvl = s.freqCmdZero & s.running & !tq;
         6'h06: lvl = (s.freqCmdZero | !s.running) & !tq;
         6'h07: lvl = s.overTorque1;
         6'h08: lvl = s.overTorque2;
         6'h09: lvl = s.powerOk & !s.abnormal;
         6'h0A: lvl = s.lowVoltageFlag;
         6'h0B: lvl = s.fault & !s.lowVoltageStop;
         6'h0D: lvl = s.overheatWarn;
         6'h0E: lvl = s.chopperActive;
         6'h0F: lvl = s.contactorReq;
         6'h10: lvl = s.slipErrorFlag & !tq;
         6'h13: lvl = s.chopperError;
         6'h14: lvl = s.warning;
         6'h15: lvl = s.overVoltWarn;
         6'h16: lvl = s.ocStall & (controlMode <= 3'h2);
         6'h17: lvl = s.ovStall;
         6'h18: lvl = cmdSrc != 8'h00;
         6'h19: lvl = s.dirForward;
         6'h1A: lvl = s.dirReverse;
         6'h1B: lvl = outCurrent >= curThr;
         6'h1C: lvl = outCurrent < curThr;
         6'h1D: lvl = outFreq >= frqThr;
         6'h1E: lvl = outFreq < frqThr;
         6'h21: lvl = s.outFreqZero & !tq;
         6'h22: lvl = (s.outFreqZero | !s.running) & !tq;
         6'h23, 6'h24, 6'h25, 6'h26: lvl = fMask[k-6'h23];
         6'h28: lvl = s.speedAttained & !tq;
         default: lvl = 1'b0;
      endcase
   endfunction
   task automatic chk(input logic [N-1:0] e, input logic [N-1:0] v,
                      input string nm = "terminalOut");
      checked++;
      if (e !== v) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, v);
      end
   endtask
   task automatic waitfor(input logic [N-1:0] v, input int lim);
      for (int k = 0; k < lim && terminalOut !== v; k++) begin
         @(negedge ref_clk);
      end
      chk(v, terminalOut);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      #1_200_000;
      n_errors++;
      stop_test();
   end
   initial begin
      seed = 89124;
      {rst, status, controlMode, outCurrent, outFreq} = {1'b1, 60'h0};
      {curThr, frqThr, relD, engD, selectCode, invMask} = '0;
      {cmdSrc, fMask} = '0;
      repeat (12) @(negedge ref_clk);
      chk('0, terminalOut);
      rst = 1'b0;
      for (it = 0; it < 400; it++) begin
         status = dsos_pkg::dsos_status_s'($random(seed));
         controlMode = 3'(it % 6);
         {outCurrent, outFreq, curThr, frqThr} = {4{16'($random(seed))}};
         if (it % 5 != 0)
            {outCurrent, outFreq} = 32'($random(seed));
         invMask = N'($random(seed));
         cmdSrc = it[1] ? 8'($random(seed)) : 8'h00;
         fMask = 4'($random(seed));
         for (j = 0; j < N; j++) begin
            c = (j == 0 && it < 42) ? 6'(it) : 6'($random(seed));
            selectCode[j*6+:6] = (c == 6'h0C || c == 6'h11) ? 6'h00 : c;
            ex[j] = lvl(selectCode[j*6+:6]) ^ invMask[j];
         end
         last = terminalOut;
         @(negedge ref_clk);
         chk(ex, terminalOut);
         chk(last, relayContact, "relayContact");
      end
      {status, invMask, selectCode} = {25'h0, 12'h000, {N{6'h11}}};
      repeat (4) @(negedge ref_clk);
      chk('0, terminalOut);
      status.fault = 1'b1;
      repeat (FD) @(negedge ref_clk);
      chk('0, terminalOut);
      waitfor('1, 4);
      selectCode = {6{6'h0B, 6'h11}};
      status.lowVoltageStop = 1'b1;
      waitfor('0, 4);
      {status, selectCode} = {25'h0, {N{6'h0C}}};
      repeat (4) @(negedge ref_clk);
      chk('0, terminalOut);
      status.running = 1'b1;
      waitfor('1, 8);
      status.running = 1'b0;
      waitfor('0, 8);
      relD = 16'h0001;
      status.running = 1'b1;
      repeat (49_990) @(negedge ref_clk);
      chk('0, terminalOut);
      waitfor('1, 20);
      stop_test();
   end
endmodule
